// ### src/ocu_pkg.sv
/*
 operate command unit package: opcode fields, auxiliary codes, timing counts,
 register offsets and carrier structs. assumes a 100 MHz clock.
*/
package ocu_pkg;
    localparam int CLK_MHZ = 100;
    localparam logic [5:0] OP_OPERATE = 6'h01;
    localparam int OP_LSB = 9;
    localparam int AUX_LSB = 3;
    localparam int ADDR_W = 3;
    localparam logic [5:0] AUX_LAMP1 = 6'h01;
    localparam logic [5:0] AUX_LAMP4 = 6'h04;
    localparam logic [5:0] AUX_SET_INACT = 6'h05;
    localparam logic [5:0] AUX_RST_INACT = 6'h06;
    localparam logic [5:0] AUX_FLAG1 = 6'h08;
    localparam logic [5:0] AUX_FLAG4 = 6'h0B;
    localparam logic [5:0] AUX_CLK_TEST = 6'h0C;
    localparam int EXEC_US = 12;
    localparam int EXEC_CYC = EXEC_US * CLK_MHZ;
    localparam int STALL_US = 31250;
    localparam int STALL_CYC = (STALL_US * CLK_MHZ + 0) / 1;
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_MASK = 8'h04;
    localparam logic [7:0] REG_LAMPS = 8'h08;
    localparam logic [7:0] REG_FLAGS = 8'h0C;
    localparam logic [7:0] REG_CLOCK = 8'h10;
    localparam logic [7:0] REG_CTRL = 8'h14;
    localparam int ST_STALL = 0;
    localparam int ST_IDLE = 1;
    localparam int ST_FLAG = 2;
    localparam int ST_DONE = 3;
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;

    typedef struct packed {
        logic [5:0] op;
        logic [5:0] aux;
    } ocu_instr_type;

    typedef struct packed {
        logic [5:0] aux;
        logic strobe;
    } ocu_ext_type;
endpackage : ocu_pkg

// ### src/ocu_operate_unit.sv
/*
 operate command unit: decodes the operate instruction and carries out its
 central-computer variations; registers over axi4-lite.
 assumes the sequencer holds instr_valid_in until done_out, and that the
 pulse inputs (32 pps, 8 s, distributor, index branch, peer flags) are
 asynchronous pin levels/pulses lasting at least three clocks.
*/
// Added by the designer: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
module ocu_operate_unit #(
    parameter int EXEC_CYCLES = ocu_pkg::EXEC_CYC,
    parameter int STALL_CYCLES = ocu_pkg::STALL_CYC,
    parameter int CLK_W = 16
) (
    input wire logic ref_clk_in,
    input wire logic srst_in,
    input wire logic instr_valid_in,
    input wire ocu_pkg::ocu_instr_type instr_in,
    output logic done_out,
    output ocu_pkg::ocu_ext_type ext_out,
    input wire logic pps32_in,
    input wire logic sec8_in,
    input wire logic distrib_run_in,
    input wire logic index_step_branch_in,
    input wire logic [3:0] peer_flag_set_in,
    output logic [3:0] peer_flag_out,
    output logic [3:0] lamp_out,
    output logic inact_alarm_out,
    output logic irq_out,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    typedef enum logic [2:0] {
        OCU_IDLE = 3'b001,
        OCU_EXEC = 3'b010,
        OCU_DONE = 3'b100
    } ocu_state_type;

    function automatic logic in_range(input logic [5:0] v, input logic [5:0] lo,
                                      input logic [5:0] hi);
        in_range = (v >= lo) && (v <= hi);
    endfunction : in_range

    // two-flop synchronisers for every pin input; stage two also feeds edge detect
    localparam int NSYNC = 8;
    logic [NSYNC-1:0] sync1_q;
    logic [NSYNC-1:0] sync2_q;
    logic [NSYNC-1:0] sync3_q;
    wire [NSYNC-1:0] raw_in = {peer_flag_set_in, index_step_branch_in, distrib_run_in,
                               sec8_in, pps32_in};
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            sync1_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
        end else begin
            sync1_q <= raw_in;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end
    wire [NSYNC-1:0] rise = sync2_q & ~sync3_q;
    wire pps_tick = rise[0];
    wire sec8_tick = rise[1];
    wire distrib_run = sync2_q[2];
    wire ixb_tick = rise[3];
    wire [3:0] peer_rise = rise[7:4];

    // instruction sequencing
    ocu_state_type state_q;
    ocu_state_type state_d;
    logic [15:0] cyc_q;
    logic [5:0] aux_q;
    wire is_operate = instr_in.op == ocu_pkg::OP_OPERATE;
    wire start = (state_q == OCU_IDLE) && instr_valid_in && is_operate;
    wire exec_end = (state_q == OCU_EXEC) && (cyc_q == 16'(EXEC_CYCLES - 2));
    // the unit pulse fires once at the start of execution
    wire unit_pulse = start;
    wire [5:0] aux = instr_in.aux;
    wire do_lamp = unit_pulse && in_range(aux, ocu_pkg::AUX_LAMP1, ocu_pkg::AUX_LAMP4);
    wire do_arm = unit_pulse && (aux == ocu_pkg::AUX_SET_INACT);
    wire do_reset = unit_pulse && (aux == ocu_pkg::AUX_RST_INACT);
    wire do_flag = unit_pulse && in_range(aux, ocu_pkg::AUX_FLAG1, ocu_pkg::AUX_FLAG4);
    wire do_clk = unit_pulse && (aux == ocu_pkg::AUX_CLK_TEST);
    wire do_ext = unit_pulse && !do_lamp && !do_arm && !do_reset && !do_flag && !do_clk;

    always_comb begin
        state_d = state_q;
        case (state_q)
            OCU_IDLE: begin
                if (start) begin
                    state_d = OCU_EXEC;
                end
            end
            OCU_EXEC: begin
                if (exec_end) begin
                    state_d = OCU_DONE;
                end
            end
            OCU_DONE: begin
                state_d = OCU_IDLE;
            end
            default: begin
                state_d = OCU_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            state_q <= OCU_IDLE;
            cyc_q <= 16'h0000;
            aux_q <= 6'h00;
        end else begin
            state_q <= state_d;
            cyc_q <= (state_q == OCU_EXEC) ? cyc_q + 16'h0001 : 16'h0000;
            if (start) begin
                aux_q <= aux;
            end
        end
    end
    assign done_out = state_q == OCU_DONE;

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            ext_out <= '0;
        end else begin
            ext_out.strobe <= do_ext;
            if (do_ext) begin
                ext_out.aux <= aux;
            end
        end
    end

    // bus write strobes used below
    logic wr_fire;
    logic [7:0] wr_addr_q;
    logic [31:0] wr_data_q;
    wire wr_lamps = wr_fire && (wr_addr_q == ocu_pkg::REG_LAMPS);
    wire wr_flags = wr_fire && (wr_addr_q == ocu_pkg::REG_FLAGS);
    wire wr_status = wr_fire && (wr_addr_q == ocu_pkg::REG_STATUS);
    wire wr_mask = wr_fire && (wr_addr_q == ocu_pkg::REG_MASK);

    // condition lamps: set wins over a software clear in the same cycle
    logic [3:0] lamp_q;
    wire [3:0] lamp_set = do_lamp ? 4'(4'h1 << (aux[1:0] - 2'h1)) : 4'h0;
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            lamp_q <= 4'h0;
        end else begin
            lamp_q <= (lamp_q & ~(wr_lamps ? wr_data_q[3:0] : 4'h0)) | lamp_set;
        end
    end
    assign lamp_out = lamp_q;

    // inactivity watch
    logic armed_q;
    logic [1:0] sec8_cnt_q;
    logic [31:0] stall_q;
    logic alarm_q;
    wire stall_hit = armed_q && (stall_q >= 32'(STALL_CYCLES - 1)) && !distrib_run;
    wire idle_hit = armed_q && sec8_tick && (sec8_cnt_q == 2'h1);
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            armed_q <= 1'b0;
            sec8_cnt_q <= 2'h0;
            stall_q <= 32'h0000_0000;
            alarm_q <= 1'b0;
        end else begin
            if (do_arm) begin
                armed_q <= 1'b1;
            end else if (do_reset) begin
                armed_q <= 1'b0;
            end
            if (do_arm || do_reset) begin
                sec8_cnt_q <= 2'h0;
            end else if (armed_q && sec8_tick && sec8_cnt_q != 2'h2) begin
                sec8_cnt_q <= sec8_cnt_q + 2'h1;
            end
            // checked every clock; counts cycles the distributor stands still
            if (!armed_q || distrib_run || do_arm) begin
                stall_q <= 32'h0000_0000;
            end else if (!stall_hit) begin
                stall_q <= stall_q + 32'h0000_0001;
            end
            if ((stall_hit || idle_hit) && !do_reset) begin
                alarm_q <= 1'b1;
            end else if (do_reset) begin
                alarm_q <= 1'b0;
            end
        end
    end
    assign inact_alarm_out = alarm_q;

    // intercommunication: outgoing pulse to peer, incoming held flags
    logic [3:0] peer_q;
    logic [3:0] icf_q;
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            peer_q <= 4'h0;
            icf_q <= 4'h0;
        end else begin
            // held high for the instruction so the peer's synchroniser sees it
            if (do_flag) begin
                peer_q <= 4'(4'h1 << aux[1:0]);
            end else if (done_out) begin
                peer_q <= 4'h0;
            end
            icf_q <= (icf_q & ~(wr_flags ? wr_data_q[3:0] : 4'h0)) | peer_rise;
        end
    end
    assign peer_flag_out = peer_q;

    // real-time clock register
    logic test_q;
    logic [CLK_W-1:0] rtc_q;
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            test_q <= 1'b0;
            rtc_q <= '0;
        end else begin
            if (do_clk) begin
                test_q <= !test_q;
            end
            if (do_clk && !test_q) begin
                rtc_q <= '0;
            end else if (test_q ? ixb_tick : pps_tick) begin
                // any rate up to half the clock rate is accepted in test
                rtc_q <= rtc_q + 1'b1;
            end
        end
    end

    // interrupt status: event bits, set wins over write-one-clear
    logic [3:0] sts_q;
    logic [3:0] msk_q;
    // bit positions come from the package so software and bench share one map
    wire [3:0] ev;
    assign ev[ocu_pkg::ST_IDLE] = idle_hit;
    assign ev[ocu_pkg::ST_STALL] = stall_hit;
    assign ev[ocu_pkg::ST_FLAG] = |peer_rise;
    assign ev[ocu_pkg::ST_DONE] = done_out;
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            sts_q <= 4'h0;
            msk_q <= 4'h0;
        end else begin
            sts_q <= (sts_q & ~(wr_status ? wr_data_q[3:0] : 4'h0)) | ev;
            if (wr_mask) begin
                msk_q <= wr_data_q[3:0];
            end
        end
    end
    assign irq_out = |(sts_q & msk_q);

    // axi4-lite slave: address and data captured independently
    logic aw_q;
    logic w_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    wire wr_known = (wr_addr_q == ocu_pkg::REG_STATUS) || (wr_addr_q == ocu_pkg::REG_MASK)
                    || (wr_addr_q == ocu_pkg::REG_LAMPS) || (wr_addr_q == ocu_pkg::REG_FLAGS);
    assign wr_fire = aw_q && w_q && !bvalid_q;
    assign s_axi_awready = !aw_q && !bvalid_q;
    assign s_axi_wready = !w_q && !bvalid_q;
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= ocu_pkg::RESP_OK;
            wr_addr_q <= 8'h00;
            wr_data_q <= 32'h0000_0000;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_q <= 1'b1;
                wr_addr_q <= {s_axi_awaddr[7:2], 2'h0};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_q <= 1'b1;
                // partial strobes: only lane 0 holds live bits
                wr_data_q <= s_axi_wstrb[0] ? s_axi_wdata : 32'h0000_0000;
            end
            if (wr_fire) begin
                aw_q <= 1'b0;
                w_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wr_known ? ocu_pkg::RESP_OK : ocu_pkg::RESP_ERR;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    wire [7:0] ra = {s_axi_araddr[7:2], 2'h0};
    wire rd_known = ra <= ocu_pkg::REG_CTRL;
    wire [31:0] rd_mux =
        (ra == ocu_pkg::REG_STATUS) ? {28'h0, sts_q} :
        (ra == ocu_pkg::REG_MASK) ? {28'h0, msk_q} :
        (ra == ocu_pkg::REG_LAMPS) ? {28'h0, lamp_q} :
        (ra == ocu_pkg::REG_FLAGS) ? {28'h0, icf_q} :
        (ra == ocu_pkg::REG_CLOCK) ? 32'(rtc_q) :
        (ra == ocu_pkg::REG_CTRL) ? {29'h0, alarm_q, armed_q, test_q} : 32'h0000_0000;
    assign s_axi_arready = !rvalid_q;
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= ocu_pkg::RESP_OK;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_mux;
            rresp_q <= rd_known ? ocu_pkg::RESP_OK : ocu_pkg::RESP_ERR;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
endmodule : ocu_operate_unit

// ### sim/ocu_operate_unit_properties.sv
/*
 port checker for the operate command unit, bound into the design.
 assumes the sequencer holds valid and the code until done_out.
*/
`timescale 1ns/1ps
module ocu_operate_unit_properties #(
    parameter int EXEC_CYCLES = 1200
) (
    input wire logic ref_clk_in,
    input wire logic srst_in,
    input wire logic instr_valid_in,
    input wire ocu_pkg::ocu_instr_type instr_in,
    input wire logic done_out,
    input wire ocu_pkg::ocu_ext_type ext_out,
    input wire logic [3:0] peer_flag_out,
    input wire logic [3:0] lamp_out,
    input wire logic inact_alarm_out,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    localparam int LO = EXEC_CYCLES - 1;
    localparam int HI = EXEC_CYCLES + 1;
    wire logic start_w = instr_valid_in && instr_in.op == ocu_pkg::OP_OPERATE;
    wire logic [5:0] aux_w = instr_in.aux;
    int run_q;
    function automatic logic local_code(input logic [5:0] a);
        return a inside {[ocu_pkg::AUX_LAMP1:ocu_pkg::AUX_RST_INACT]}
            || a inside {[ocu_pkg::AUX_FLAG1:ocu_pkg::AUX_CLK_TEST]};
    endfunction : local_code
    // edges the present operate has been offered; refused opcodes never count
    always_ff @(posedge ref_clk_in) begin
        if (srst_in || !start_w) run_q <= 0;
        else run_q <= run_q + 1;
    end
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (srst_in);
    done_time_a: assert property (done_out |-> run_q >= LO && run_q <= HI)
        else $error("operate ended at the wrong time");
    exec_bound_a: assert property (start_w |-> run_q <= HI)
        else $error("operate did not end");
    lamp_on_a: assert property (
        $rose(start_w) && aux_w inside {[ocu_pkg::AUX_LAMP1:ocu_pkg::AUX_LAMP4]}
        |-> ##[1:2] lamp_out[aux_w - ocu_pkg::AUX_LAMP1]) else $error("lamp not lit");
    peer_set_a: assert property (
        $rose(start_w) && aux_w inside {[ocu_pkg::AUX_FLAG1:ocu_pkg::AUX_FLAG4]}
        |-> ##[1:2] peer_flag_out[aux_w - ocu_pkg::AUX_FLAG1]) else $error("peer flag missing");
    peer_only_a: assert property (
        |peer_flag_out |-> $onehot(peer_flag_out) && (start_w || $past(start_w)))
        else $error("stray peer flag");
    ext_route_a: assert property (
        $rose(start_w) && !local_code(aux_w) |-> ##[1:2] ext_out.strobe && ext_out.aux == aux_w)
        else $error("code not routed out");
    ext_quiet_a: assert property (ext_out.strobe |-> !local_code(ext_out.aux))
        else $error("local code routed out");
    alarm_off_a: assert property (
        $rose(start_w) && aux_w == ocu_pkg::AUX_RST_INACT |-> ##[1:2] !inact_alarm_out)
        else $error("alarm survived reset code");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    rdata_hold_a: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    reset_clear_a: assert property ($fell(srst_in) |->
        lamp_out == 4'h0 && peer_flag_out == 4'h0 && !inact_alarm_out && !done_out)
        else $error("outputs not clear after reset");
    cover property (done_out);
    cover property ($rose(inact_alarm_out));
    cover property (ext_out.strobe);
endmodule : ocu_operate_unit_properties

bind ocu_operate_unit ocu_operate_unit_properties #(.EXEC_CYCLES(EXEC_CYCLES)) props_u (
    .ref_clk_in, .srst_in, .instr_valid_in, .instr_in, .done_out, .ext_out, .peer_flag_out,
    .lamp_out, .inact_alarm_out, .s_axi_bvalid, .s_axi_bready, .s_axi_rdata, .s_axi_rvalid,
    .s_axi_rready
);

// ### sim/ocu_seq_model.sv
/*
 instruction sequencer stand-in: offers one code after a chosen lag and holds it.
 assumes one start pulse per instruction and no start while one is held.
*/
`timescale 1ns/1ps
module ocu_seq_model (
    input wire logic clk_in,
    input wire logic start_in,
    input wire logic stop_in,
    input wire ocu_pkg::ocu_instr_type code_in,
    input wire logic [3:0] lag_in,
    input wire logic done_in,
    output logic valid_out,
    output ocu_pkg::ocu_instr_type instr_out
);
    logic [3:0] wait_q = 4'h0;
    logic armed_q = 1'b0;
    initial valid_out = 1'b0;
    initial instr_out = '0;
    always @(posedge clk_in) begin
        if (start_in) begin
            armed_q <= 1'b1;
            wait_q <= lag_in;
        end else if (armed_q && wait_q != 4'h0) begin
            wait_q <= wait_q - 4'h1;
        end else if (armed_q) begin
            armed_q <= 1'b0;
            valid_out <= 1'b1;
            instr_out <= code_in;
        end
        // a released code is scrambled so nothing can lean on the old value
        if (valid_out && (done_in || stop_in)) begin
            valid_out <= 1'b0;
            instr_out <= ~instr_out;
        end
    end
endmodule : ocu_seq_model

// ### sim/ocu_operate_unit_tb.sv
/*
 self-checking bench for the operate command unit: instructions via the
 sequencer model, registers via axi4-lite. assumes short sim counts.
*/
`timescale 1ns/1ps
module ocu_operate_unit_tb;
    localparam int EXEC_SIM = 8;
    localparam int STALL_SIM = 20;
    localparam logic [1:0] OK = ocu_pkg::RESP_OK;
    localparam logic [5:0] OPR = ocu_pkg::OP_OPERATE;
    logic ref_clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic start_q = 1'b0;
    logic stop_q = 1'b0;
    logic [3:0] lag_q = 4'h0;
    ocu_pkg::ocu_instr_type code_q = '0;
    ocu_pkg::ocu_instr_type instr_in;
    ocu_pkg::ocu_ext_type ext_out;
    logic instr_valid_in, done_out, inact_alarm_out, irq_out;
    logic [3:0] peer_flag_out, lamp_out;
    logic [7:0] pins_q = 8'h00;
    logic distrib_q = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [5:0] codes [7] = '{6'h07, 6'h08, 6'h09, 6'h0A, 6'h0B, 6'h0D, 6'h3F};
    int errors = 0;
    int compares = 0;

    always #5 ref_clk_in = ~ref_clk_in;

    ocu_operate_unit #(.EXEC_CYCLES(EXEC_SIM), .STALL_CYCLES(STALL_SIM)) dut_u (
        .ref_clk_in, .srst_in, .instr_valid_in, .instr_in, .done_out, .ext_out,
        .pps32_in(pins_q[0]), .sec8_in(pins_q[1]), .distrib_run_in(distrib_q),
        .index_step_branch_in(pins_q[2]), .peer_flag_set_in(pins_q[7:4]), .peer_flag_out,
        .lamp_out, .inact_alarm_out, .irq_out, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
    );
    ocu_seq_model seq_u (.clk_in(ref_clk_in), .start_in(start_q), .stop_in(stop_q),
        .code_in(code_q), .lag_in(lag_q), .done_in(done_out), .valid_out(instr_valid_in),
        .instr_out(instr_in));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic tally_and_finish;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish

    // bready/rready stand from the request until the answer is sampled
    task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d,
            input logic [31:0] exp, input logic [1:0] er, input string what);
        logic fin;
        fin = 1'b0;
        @(posedge ref_clk_in);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= wr;
        s_axi_wvalid <= wr;
        s_axi_bready <= wr;
        s_axi_arvalid <= !wr;
        s_axi_rready <= !wr;
        while (!fin) begin
            @(posedge ref_clk_in);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready)) begin
                fin = 1'b1;
                s_axi_bready <= 1'b0;
                s_axi_rready <= 1'b0;
                chk(32'(wr ? s_axi_bresp : s_axi_rresp), 32'(er), what);
                if (!wr) chk(s_axi_rdata, exp, what);
            end
        end
    endtask : axi

    task automatic op_run(input logic [5:0] op, input logic [5:0] aux);
        int n;
        logic [3:0] seen;
        logic hit;
        logic ok;
        n = 0;
        seen = 4'h0;
        hit = 1'b0;
        ok = op == OPR;
        @(posedge ref_clk_in);
        code_q <= {op, aux};
        lag_q <= aux[3:0];
        start_q <= 1'b1;
        @(posedge ref_clk_in);
        start_q <= 1'b0;
        while (!done_out && n < 40) begin
            @(posedge ref_clk_in);
            n += int'(instr_valid_in);
            seen |= peer_flag_out;
            hit |= ext_out.strobe && ext_out.aux == aux;
        end
        stop_q <= 1'b1;
        @(posedge ref_clk_in);
        stop_q <= 1'b0;
        chk(32'(ok ? n >= EXEC_SIM && n <= EXEC_SIM + 2 : n == 40), 1, "exec time");
        chk(32'(seen), 32'(ok && aux inside {[8:11]} ? 4'h1 << (aux - 6'h08) : 4'h0), "peer");
        chk(32'(hit), 32'(ok && !(aux inside {[1:6], [8:12]})), "routed");
    endtask : op_run

    task automatic pulse(input int i, input int times);
        repeat (times) begin
            @(posedge ref_clk_in);
            pins_q[i] <= 1'b1;
            repeat (4) @(posedge ref_clk_in);
            pins_q[i] <= 1'b0;
            repeat (4) @(posedge ref_clk_in);
        end
    endtask : pulse

    task automatic stall(input int c);
        @(posedge ref_clk_in);
        distrib_q <= 1'b0;
        repeat (c) @(posedge ref_clk_in);
        distrib_q <= 1'b1;
    endtask : stall

    initial begin
        repeat (20000) @(posedge ref_clk_in);
        errors++;
        $display("Error at %0t: watchdog expired", $time);
        tally_and_finish();
    end

    initial begin
        repeat (5) @(posedge ref_clk_in);
        srst_in <= 1'b0;
        for (int i = 0; i < 6; i++) axi(0, 8'(4 * i), 0, 0, OK, "reset value");
        axi(0, 8'h18, 0, 0, ocu_pkg::RESP_ERR, "unmapped read");
        axi(1, 8'h18, 32'hF, 0, ocu_pkg::RESP_ERR, "unmapped write");
        for (int a = 1; a <= 4; a++) begin
            op_run(OPR, 6'(a));
            axi(0, ocu_pkg::REG_LAMPS, 0, 32'((1 << a) - 1), OK, "lamps");
        end
        axi(1, ocu_pkg::REG_LAMPS, 32'hF, 0, OK, "lamp clear");
        op_run(6'h3E, 6'h01);
        axi(0, ocu_pkg::REG_LAMPS, 0, 0, OK, "refused opcode");
        foreach (codes[i]) op_run(OPR, codes[i]);
        pulse(5, 1);
        pulse(7, 1);
        axi(0, ocu_pkg::REG_FLAGS, 0, 32'hA, OK, "received flags");
        axi(1, ocu_pkg::REG_FLAGS, 32'h2, 0, OK, "flag clear");
        axi(0, ocu_pkg::REG_FLAGS, 0, 32'h8, OK, "flag kept");
        axi(1, ocu_pkg::REG_STATUS, 32'hF, 0, OK, "status clear");
        op_run(OPR, ocu_pkg::AUX_SET_INACT);
        stall(STALL_SIM - 5);
        axi(0, ocu_pkg::REG_CTRL, 0, 32'h2, OK, "short stall");
        stall(STALL_SIM + 10);
        axi(0, ocu_pkg::REG_CTRL, 0, 32'h6, OK, "stall alarm");
        axi(0, ocu_pkg::REG_STATUS, 0, 32'(1 << ocu_pkg::ST_DONE | 1 << ocu_pkg::ST_STALL),
            OK, "stall status");
        op_run(OPR, ocu_pkg::AUX_RST_INACT);
        stall(STALL_SIM + 10);
        axi(0, ocu_pkg::REG_CTRL, 0, 0, OK, "disarmed");
        axi(1, ocu_pkg::REG_STATUS, 32'hF, 0, OK, "status clear");
        axi(1, ocu_pkg::REG_MASK, 32'(1 << ocu_pkg::ST_IDLE), 0, OK, "mask");
        op_run(OPR, ocu_pkg::AUX_SET_INACT);
        pulse(1, 1);
        op_run(OPR, ocu_pkg::AUX_SET_INACT);
        pulse(1, 1);
        chk(32'({inact_alarm_out, irq_out}), 0, "one pulse, done masked");
        pulse(1, 1);
        chk(32'({inact_alarm_out, irq_out}), 32'h3, "idle alarm");
        axi(1, ocu_pkg::REG_STATUS, 32'(1 << ocu_pkg::ST_IDLE), 0, OK, "irq clear");
        axi(0, ocu_pkg::REG_STATUS, 0, 32'(1 << ocu_pkg::ST_DONE), OK, "status");
        chk(32'(irq_out), 0, "irq after clear");
        op_run(OPR, ocu_pkg::AUX_RST_INACT);
        chk(32'(inact_alarm_out), 0, "alarm reset");
        pulse(0, 3);
        axi(0, ocu_pkg::REG_CLOCK, 0, 32'h3, OK, "clock");
        op_run(OPR, ocu_pkg::AUX_CLK_TEST);
        pulse(0, 2);
        pulse(2, 5);
        axi(0, ocu_pkg::REG_CLOCK, 0, 32'h5, OK, "test clock");
        axi(0, ocu_pkg::REG_CTRL, 0, 32'h1, OK, "test mode");
        op_run(OPR, ocu_pkg::AUX_CLK_TEST);
        pulse(2, 1);
        pulse(0, 1);
        axi(0, ocu_pkg::REG_CLOCK, 0, 32'h6, OK, "reattached");
        tally_and_finish();
    end
endmodule : ocu_operate_unit_tb
